// ### rtl/rnc_rotate_unit.sv
// Rotate instruction execution unit with APB register access
//
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
module rnc_rotate_unit
   import rnc_pkg::*;
#(
   parameter int unsigned BANK_W = 4
) (
   input  wire logic        CLK_SYS_I,
   input  wire logic        RESET_I,
   input  wire logic        CE_I,
   input  wire logic        PSEL_I,
   input  wire logic        PENABLE_I,
   input  wire logic        PWRITE_I,
   input  wire logic [11:0] PADDR_I,
   input  wire logic [31:0] PWDATA_I,
   output logic      [31:0] PRDATA_O,
   output logic             PREADY_O,
   output logic             PSLVERR_O,
   input  wire logic [15:0] INSTR_I,
   input  wire logic        INSTR_VALID_I,
   output logic             INSTR_READY_O,
   output logic             INSTR_DONE_O
);
   localparam int unsigned MAW = BANK_W + RNC_FADDR_W;

   // Core state
   rnc_core_e         state,  next_state;
   logic [15:0]       instr,  next_instr;
   logic [MAW-1:0]    fa,     next_fa;
   logic [7:0]        result, next_result;
   logic              carry,  next_carry;
   logic              next_ready;
   logic              next_done;

   // Bus and architectural state
   rnc_apb_e          ap_state, next_ap_state;
   logic [7:0]        work,     next_work;
   logic [BANK_W-1:0] bank_pointer_reg, next_bank_pointer_reg;
   logic [2:0]        flags,    next_flags;
   logic [MAW-1:0]    faddr,    next_faddr;
   logic              illegal,  next_illegal;
   logic [31:0]       next_prdata;
   logic              next_pready;
   logic              next_pslverr;

   logic              mem_we;
   logic [MAW-1:0]    mem_addr;
   logic [7:0]        mem_wdata;
   logic [7:0]        mem_rdata;

   logic [5:0]        opc;
   logic              is_rr, is_rl, is_rrc, legal, dest_file;
   logic              accept, core_wr_work, core_wr_flags;
   logic              acc, is_fdata, port_free, apb_fire;

   assign opc       = instr[15:RNC_OPC_LSB];
   assign is_rr     = (opc == RNC_OPC_RRNC);
   assign is_rl     = (opc == RNC_OPC_RLNC);
   assign is_rrc    = (opc == RNC_OPC_RRC);
   assign legal     = is_rr | is_rl | is_rrc;
   assign dest_file = instr[RNC_POS_DEST];
   assign accept    = INSTR_VALID_I & INSTR_READY_O & (state == RNC_S_DECODE);
   assign acc       = PSEL_I & PENABLE_I;
   assign is_fdata  = (PADDR_I == RNC_OFS_FDATA);
   // Bus gets the memory port only while the core sits idle in decode
   assign port_free = (state == RNC_S_DECODE) & ~accept;
   assign apb_fire  = acc & PREADY_O;

   assign core_wr_work  = (state == RNC_S_WRITE) & legal & ~dest_file;
   assign core_wr_flags = (state == RNC_S_WRITE) & legal;

   // Memory port arbitration
   always_comb begin
      mem_we    = 1'b0;
      mem_addr  = fa;
      mem_wdata = result;
      if (state == RNC_S_READ) begin
         mem_addr = next_fa;
      end else if (state == RNC_S_WRITE) begin
         mem_we = legal & dest_file;
      end else if (ap_state == RNC_A_DONE && is_fdata && PWRITE_I) begin
         mem_addr  = faddr;
         mem_wdata = PWDATA_I[7:0];
         mem_we    = apb_fire;
      end else begin
         mem_addr = faddr;
      end
   end

   rnc_file_ram #(
      .AW (MAW),
      .DW (RNC_DATA_W)
   ) u_ram (
      .clk_i   (CLK_SYS_I),
      .reset_i (RESET_I),
      .ce_i    (CE_I),
      .we_i    (mem_we),
      .addr_i  (mem_addr),
      .wdata_i (mem_wdata),
      .rdata_o (mem_rdata)
   );

   // Core sequence: four clocks per instruction
   always_comb begin
      next_state  = state;
      next_instr  = instr;
      next_fa     = fa;
      next_result = result;
      next_carry  = carry;
      next_done   = 1'b0;
      case (state)
         RNC_S_DECODE: begin
            if (accept) begin
               next_instr = INSTR_I;
               next_state = RNC_S_READ;
            end
         end
         RNC_S_READ: begin
            if (instr[RNC_POS_BANKSEL]) begin
               next_fa = {bank_pointer_reg, instr[RNC_FADDR_W-1:0]};
            end else begin
               next_fa = {BANK_W'(RNC_ACCESS_BANK), instr[RNC_FADDR_W-1:0]};
            end
            next_state = RNC_S_PROC;
         end
         RNC_S_PROC: begin
            next_carry = flags[RNC_FLAG_C];
            if (is_rr) begin
               next_result = {mem_rdata[0], mem_rdata[7:1]};
            end else if (is_rl) begin
               next_result = {mem_rdata[6:0], mem_rdata[7]};
            end else begin
               next_result = {flags[RNC_FLAG_C], mem_rdata[7:1]};
               next_carry  = mem_rdata[0];
            end
            next_state = RNC_S_WRITE;
         end
         RNC_S_WRITE: begin
            next_done  = 1'b1;
            next_state = RNC_S_DECODE;
         end
         default: begin
            next_state = RNC_S_DECODE;
         end
      endcase
      // Holding ready low while the bus claims the port avoids a clash at issue
      next_ready = (next_state == RNC_S_DECODE) && (next_ap_state == RNC_A_IDLE) && !(PSEL_I && is_fdata);
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         state         <= RNC_S_DECODE;
         instr         <= '0;
         fa            <= '0;
         result        <= '0;
         carry         <= 1'b0;
         INSTR_READY_O <= 1'b0;
         INSTR_DONE_O  <= 1'b0;
      end else if (CE_I) begin
         state         <= next_state;
         instr         <= next_instr;
         fa            <= next_fa;
         result        <= next_result;
         carry         <= next_carry;
         INSTR_READY_O <= next_ready;
         INSTR_DONE_O  <= next_done;
      end
   end

   // APB slave and architectural registers
   always_comb begin
      next_ap_state         = ap_state;
      next_work             = work;
      next_bank_pointer_reg = bank_pointer_reg;
      next_flags            = flags;
      next_faddr            = faddr;
      next_illegal          = illegal;
      next_prdata           = PRDATA_O;
      next_pready           = 1'b0;
      next_pslverr          = 1'b0;
      case (ap_state)
         RNC_A_IDLE: begin
            if (acc && is_fdata) begin
               if (port_free) begin
                  next_pslverr  = 1'b0;
                  next_prdata   = '0;
                  next_ap_state = PWRITE_I ? RNC_A_DONE : RNC_A_MEM;
                  next_pready   = PWRITE_I;
               end
            end else if (acc) begin
               next_pslverr  = 1'b0;
               next_pready   = 1'b1;
               next_ap_state = RNC_A_DONE;
               case (PADDR_I)
                  RNC_OFS_WORK:   next_prdata = {24'h0, work};
                  RNC_OFS_BANK:   next_prdata = 32'(bank_pointer_reg);
                  RNC_OFS_FLAGS:  next_prdata = {29'h0, flags};
                  RNC_OFS_STATUS: next_prdata = {30'h0, illegal, state != RNC_S_DECODE};
                  RNC_OFS_FADDR:  next_prdata = 32'(faddr);
                  default: begin
                     next_prdata  = '0;
                     next_pslverr = 1'b1;
                  end
               endcase
            end
         end
         RNC_A_MEM: begin
            next_prdata   = {24'h0, mem_rdata};
            next_pready   = 1'b1;
            next_ap_state = RNC_A_DONE;
         end
         RNC_A_DONE: begin
            next_ap_state = RNC_A_IDLE;
         end
         default: begin
            next_ap_state = RNC_A_IDLE;
         end
      endcase
      // Writes take effect only at the edge that completes the transfer
      if (apb_fire && PWRITE_I) begin
         case (PADDR_I)
            RNC_OFS_WORK:   next_work             = PWDATA_I[7:0];
            RNC_OFS_BANK:   next_bank_pointer_reg = PWDATA_I[BANK_W-1:0];
            RNC_OFS_FLAGS:  next_flags            = PWDATA_I[2:0];
            RNC_OFS_STATUS: next_illegal          = illegal & ~PWDATA_I[RNC_STAT_ILL];
            RNC_OFS_FADDR:  next_faddr            = PWDATA_I[MAW-1:0];
            default: begin
               next_faddr = faddr;
            end
         endcase
      end
      // Core updates win over a bus write in the same cycle
      if (core_wr_work) begin
         next_work = result;
      end
      if (core_wr_flags) begin
         next_flags[RNC_FLAG_N] = result[7];
         next_flags[RNC_FLAG_Z] = (result == 8'h00);
         next_flags[RNC_FLAG_C] = is_rrc ? carry : flags[RNC_FLAG_C];
      end
      if (state == RNC_S_WRITE && !legal) begin
         next_illegal = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS_I) begin
      if (RESET_I) begin
         ap_state         <= RNC_A_IDLE;
         work             <= RNC_WORK_RST;
         bank_pointer_reg <= BANK_W'(RNC_BANK_RST);
         flags            <= RNC_FLAGS_RST;
         faddr            <= '0;
         illegal          <= 1'b0;
         PRDATA_O         <= '0;
         PREADY_O         <= 1'b0;
         PSLVERR_O        <= 1'b0;
      end else if (CE_I) begin
         ap_state         <= next_ap_state;
         work             <= next_work;
         bank_pointer_reg <= next_bank_pointer_reg;
         flags            <= next_flags;
         faddr            <= next_faddr;
         illegal          <= next_illegal;
         PRDATA_O         <= next_prdata;
         PREADY_O         <= next_pready;
         PSLVERR_O        <= next_pslverr;
      end
   end
endmodule

// ### rtl/rnc_pkg.sv
// Constants, offsets and state types for the rotate execution unit
package rnc_pkg;
   // Instruction fields
   localparam int unsigned RNC_DATA_W      = 8;
   localparam int unsigned RNC_FADDR_W     = 8;
   localparam int unsigned RNC_OPC_LSB     = 10;
   localparam int unsigned RNC_POS_DEST    = 9;
   localparam int unsigned RNC_POS_BANKSEL = 8;
   localparam logic [5:0]  RNC_OPC_RRNC    = 6'h10;
   localparam logic [5:0]  RNC_OPC_RLNC    = 6'h11;
   localparam logic [5:0]  RNC_OPC_RRC     = 6'h0c;

   // Register byte offsets
   localparam logic [11:0] RNC_OFS_WORK    = 12'h000;
   localparam logic [11:0] RNC_OFS_BANK    = 12'h004;
   localparam logic [11:0] RNC_OFS_FLAGS   = 12'h008;
   localparam logic [11:0] RNC_OFS_STATUS  = 12'h00c;
   localparam logic [11:0] RNC_OFS_FADDR   = 12'h010;
   localparam logic [11:0] RNC_OFS_FDATA   = 12'h014;

   // Flag and status bit positions
   localparam int unsigned RNC_FLAG_C      = 0;
   localparam int unsigned RNC_FLAG_Z      = 1;
   localparam int unsigned RNC_FLAG_N      = 2;
   localparam int unsigned RNC_STAT_BUSY   = 0;
   localparam int unsigned RNC_STAT_ILL    = 1;

   // Reset values and access bank
   localparam logic [7:0]  RNC_WORK_RST    = 8'h00;
   localparam logic [2:0]  RNC_FLAGS_RST   = 3'h0;
   localparam int unsigned RNC_BANK_RST    = 0;
   localparam int unsigned RNC_ACCESS_BANK = 0;

   typedef enum logic [1:0] {
      RNC_S_DECODE = 2'b00,
      RNC_S_READ   = 2'b01,
      RNC_S_PROC   = 2'b10,
      RNC_S_WRITE  = 2'b11
   } rnc_core_e;

   typedef enum logic [1:0] {
      RNC_A_IDLE = 2'b00,
      RNC_A_MEM  = 2'b01,
      RNC_A_DONE = 2'b10
   } rnc_apb_e;
endpackage

// ### rtl/rnc_file_ram.sv
// Single-port file register memory with registered read data
`timescale 1ns/1ps
module rnc_file_ram #(
   parameter int unsigned AW = 12,
   parameter int unsigned DW = 8
) (
   input  wire logic          clk_i,
   input  wire logic          reset_i,
   input  wire logic          ce_i,
   input  wire logic          we_i,
   input  wire logic [AW-1:0] addr_i,
   input  wire logic [DW-1:0] wdata_i,
   output logic      [DW-1:0] rdata_o
);
   logic [DW-1:0] mem [0:(1<<AW)-1];

   // Contents are not reset; software must initialise what it uses
   always_ff @(posedge clk_i) begin
      if (ce_i && we_i) begin
         mem[addr_i] <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         rdata_o <= '0;
      end else if (ce_i) begin
         rdata_o <= mem[addr_i];
      end
   end
endmodule

// ### dv/rnc_rotate_unit_checker.sv
// Port assertions for the rotate execution unit
`timescale 1ns/1ps
module rnc_rotate_unit_checker (
   input wire logic        CLK_SYS_I,
   input wire logic        RESET_I,
   input wire logic        CE_I,
   input wire logic        PSEL_I,
   input wire logic        PENABLE_I,
   input wire logic        PWRITE_I,
   input wire logic [11:0] PADDR_I,
   input wire logic [31:0] PWDATA_I,
   input wire logic [31:0] PRDATA_O,
   input wire logic        PREADY_O,
   input wire logic        PSLVERR_O,
   input wire logic [15:0] INSTR_I,
   input wire logic        INSTR_VALID_I,
   input wire logic        INSTR_READY_O,
   input wire logic        INSTR_DONE_O
);
   default clocking cb @(posedge CLK_SYS_I); endclocking
   // Frozen enable holds every output, so those cycles are skipped
   default disable iff (RESET_I || !CE_I);
   sequence taken_s; INSTR_VALID_I && INSTR_READY_O; endsequence
   sequence done_s; !INSTR_DONE_O [*3] ##1 INSTR_DONE_O; endsequence
   ready_pulse_a: assert property (PREADY_O |=> !PREADY_O)
      else $error("bus ready held over one cycle");
   ready_cause_a: assert property (PREADY_O |-> $past(PSEL_I && PENABLE_I))
      else $error("bus ready without access phase");
   err_ready_a: assert property (PSLVERR_O |-> PREADY_O && PRDATA_O == 32'h0)
      else $error("bus error without ready or with data");
   rst_quiet_a: assert property ($past(RESET_I) |-> !PREADY_O && !PSLVERR_O && !INSTR_READY_O && !INSTR_DONE_O)
      else $error("outputs active right after reset");
   done_time_a: assert property (taken_s |=> done_s)
      else $error("done not exactly four cycles after take");
   busy_low_a: assert property (taken_s |=> !INSTR_READY_O [*3])
      else $error("ready while instruction in flight");
   done_pulse_a: assert property (INSTR_DONE_O |=> !INSTR_DONE_O)
      else $error("done longer than one cycle");
   done_cause_a: assert property ($rose(INSTR_DONE_O) |-> $past(INSTR_VALID_I && INSTR_READY_O, 4))
      else $error("done without a taken instruction");
endmodule
bind rnc_rotate_unit rnc_rotate_unit_checker chk (.CLK_SYS_I(CLK_SYS_I), .RESET_I(RESET_I), .CE_I(CE_I),
   .PSEL_I(PSEL_I), .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I), .PWDATA_I(PWDATA_I),
   .PRDATA_O(PRDATA_O), .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O), .INSTR_I(INSTR_I),
   .INSTR_VALID_I(INSTR_VALID_I), .INSTR_READY_O(INSTR_READY_O), .INSTR_DONE_O(INSTR_DONE_O));

// ### dv/rnc_rotate_unit_test.sv
// Self-checking bench for the rotate execution unit
`timescale 1ns/1ps
module rnc_rotate_unit_test;
   import rnc_pkg::*;
   typedef struct packed {
      logic [5:0] op;
      logic       d;
      logic       a;
      logic [7:0] opnd;
      logic [7:0] res;
      logic [2:0] flg;
   } rnc_row_s;
   logic        clk    = 1'b0;
   logic        rst    = 1'b1;
   logic        psel   = 1'b0;
   logic        pen    = 1'b0;
   logic        pwr    = 1'b0;
   logic [11:0] paddr  = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [15:0] instr  = 16'h0;
   logic        ivalid = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        iready;
   logic        idone;
   logic        err;
   int          fail_count = 0;
   int          compares   = 0;
   rnc_row_s    r;
   // Carry preset to 1, so no-carry rotates must leave it set
   rnc_row_s    rows [7] = '{'{RNC_OPC_RRNC, 1'b1, 1'b0, 8'hd7, 8'heb, 3'h5},
      '{RNC_OPC_RRNC, 1'b0, 1'b0, 8'hd7, 8'heb, 3'h5}, '{RNC_OPC_RLNC, 1'b1, 1'b1, 8'hab, 8'h57, 3'h1},
      '{RNC_OPC_RRNC, 1'b1, 1'b1, 8'h01, 8'h80, 3'h5}, '{RNC_OPC_RRNC, 1'b0, 1'b1, 8'h00, 8'h00, 3'h3},
      '{RNC_OPC_RLNC, 1'b0, 1'b0, 8'h80, 8'h01, 3'h1}, '{RNC_OPC_RRC, 1'b1, 1'b0, 8'he6, 8'hf3, 3'h4}};
   always #2 clk = ~clk;
   rnc_rotate_unit dut (.CLK_SYS_I(clk), .RESET_I(rst), .CE_I(1'b1), .PSEL_I(psel), .PENABLE_I(pen),
      .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
      .PSLVERR_O(pslverr), .INSTR_I(instr), .INSTR_VALID_I(ivalid), .INSTR_READY_O(iready),
      .INSTR_DONE_O(idone));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // One idle cycle after each transfer keeps psel edges apart
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      int n;
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         test_done;
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] x;
      apb(1'b1, a, d, x);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] x;
      apb(1'b0, a, 32'h0, x);
      check(x, e);
   endtask
   task automatic run(input logic [15:0] w);
      int n;
      instr <= w;
      ivalid <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (iready !== 1'b1 && n < 50);
      if (n >= 50) begin
         fail_count++;
         test_done;
      end
      ivalid <= 1'b0;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (idone !== 1'b1 && n < 50);
      check(n, 4);
      if (n >= 50) begin
         test_done;
      end
   endtask
   initial begin
      repeat (6) @(posedge clk);
      check({pready, pslverr, iready, idone}, 4'h0);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      check(iready, 1'b1);
      for (int i = 0; i < 7; i++) begin
         r = rows[i];
         wr(RNC_OFS_BANK, 32'h1);
         wr(RNC_OFS_FLAGS, 32'h1);
         wr(RNC_OFS_WORK, 32'h5a);
         wr(RNC_OFS_FADDR, 32'h033);
         wr(RNC_OFS_FDATA, r.a ? 32'ha5 : {24'h0, r.opnd});
         wr(RNC_OFS_FADDR, 32'h133);
         wr(RNC_OFS_FDATA, r.a ? {24'h0, r.opnd} : 32'ha5);
         run({r.op, r.d, r.a, 8'h33});
         rd(RNC_OFS_WORK, r.d ? 32'h5a : {24'h0, r.res});
         rd(RNC_OFS_FLAGS, {29'h0, r.flg});
         wr(RNC_OFS_FADDR, r.a ? 32'h133 : 32'h033);
         rd(RNC_OFS_FDATA, {24'h0, r.d ? r.res : r.opnd});
         wr(RNC_OFS_FADDR, r.a ? 32'h033 : 32'h133);
         rd(RNC_OFS_FDATA, 32'ha5);
      end
      run({6'h3f, 2'b11, 8'h33});
      rd(RNC_OFS_FDATA, 32'ha5);
      rd(RNC_OFS_STATUS, 32'h2);
      wr(RNC_OFS_STATUS, 32'h2);
      rd(RNC_OFS_STATUS, 32'h0);
      run({RNC_OPC_RRNC, 2'b11, 8'h33});
      run({RNC_OPC_RRNC, 2'b11, 8'h33});
      rd(RNC_OFS_FDATA, 32'h69);
      rd(12'h018, 32'h0);
      check(err, 1'b1);
      // Status read while an instruction is in flight must show busy
      instr  <= {RNC_OPC_RRNC, 2'b01, 8'h33};
      ivalid <= 1'b1;
      @(posedge clk);
      check(iready, 1'b1);
      ivalid <= 1'b0;
      rd(RNC_OFS_STATUS, 32'h1);
      check(err, 1'b0);
      rd(RNC_OFS_WORK, 32'hb4);
      rd(RNC_OFS_FLAGS, 32'h4);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd(RNC_OFS_WORK, 32'h0);
      rd(RNC_OFS_FLAGS, 32'h0);
      test_done;
   end
endmodule
